// ### kbo_pkg.sv
// constants and types for the key and text byte-order steering block
package kbo_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          ORD_W        = 6;
  localparam int          MODE_W       = 3;
  // register offsets, byte addresses
  localparam logic [7:0]  OFF_KEY_BASE = 8'h00;
  localparam logic [7:0]  OFF_TEXT_BASE = 8'h20;
  localparam logic [7:0]  OFF_ORDER    = 8'h30;
  localparam logic [7:0]  OFF_MODE     = 8'h34;
  localparam logic [7:0]  OFF_START    = 8'h38;
  localparam logic [7:0]  OFF_IDLE     = 8'h3c;
  // byte_order_control field positions
  localparam int          ORD_KEY_BYTE = 0;
  localparam int          ORD_KEY_WORD = 1;
  localparam int          ORD_IN_BYTE  = 2;
  localparam int          ORD_IN_COL   = 3;
  localparam int          ORD_OUT_BYTE = 4;
  localparam int          ORD_OUT_COL  = 5;
  // operation select field and start bit
  localparam int          MODE_DEC_BIT = 2;
  localparam logic [1:0]  KL_BAD       = 2'h3;
  localparam int          START_BIT    = 0;
  // reset values
  localparam logic [5:0]  ORDER_RST    = 6'h00;
  localparam logic [2:0]  MODE_RST     = 3'h0;
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } kbo_state_t;
endpackage

// ### kbo_steer.sv
// key and text byte-lane steering around a block-cipher core
// Contract
// - order bits 1:0 arrange key bytes
// - order bits 3:2 arrange input text
// - order bits 5:4 arrange output text
// - input ordering on plain or cipher input
// - output ordering on produced result
// - state built only from text registers
// - text column from register 3-c or c
// - text row lane msb-first or lsb-first
// - key registers form first Nk words
// - 128-bit word i from reg 3-i or i
// - key byte order msb-first or reversed
// - word bytes taken from lanes, msb first
// - key regs 0-3, 0-5, 0-7 by length
// - word reversal spans Nk words
// - software loads text, result overwrites it
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module kbo_steer (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [7:0]   bus_addr,
  input  wire logic [31:0]  bus_wdata,
  input  wire logic         bus_wr,
  input  wire logic         bus_rd,
  output logic      [31:0]  bus_rdata,
  output logic              cipher_start,
  output logic      [255:0] cipher_key_words,
  output logic      [1:0]   cipher_key_len,
  output logic              cipher_decrypt,
  output logic      [127:0] cipher_state,
  input  wire logic         cipher_done,
  input  wire logic [127:0] cipher_result,
  output logic              busy
);
  logic [31:0]          key_reg   [8];
  logic [31:0]          key_next  [8];
  logic [31:0]          text_reg  [4];
  logic [31:0]          text_next [4];
  logic [5:0]           ctrl_reg;
  logic [5:0]           ctrl_next;
  logic [2:0]           mode_reg;
  logic [2:0]           mode_next;
  kbo_pkg::kbo_state_t  st_reg;
  kbo_pkg::kbo_state_t  st_next;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;
  logic                 start_reg;
  logic                 start_next;
  logic [255:0]         kw_reg;
  logic [255:0]         kw_next;
  logic [1:0]           kl_reg;
  logic [1:0]           kl_next;
  logic                 dec_reg;
  logic                 dec_next;
  logic [127:0]         state_reg;
  logic [127:0]         state_next;
  logic                 busy_reg;
  logic                 busy_next;
  logic                 key_hit;
  logic                 text_hit;
  logic                 idle;
  logic                 go;
  logic                 wb;
  logic [3:0]           nk;
  logic [2:0]           ksrc;
  logic [1:0]           tsrc;
  logic [1:0]           lane;

  assign key_hit  = bus_addr[7:5] == kbo_pkg::OFF_KEY_BASE[7:5];
  assign text_hit = bus_addr[7:4] == kbo_pkg::OFF_TEXT_BASE[7:4];
  assign idle     = st_reg == kbo_pkg::ST_IDLE;
  // codes 3 and 7 name no key length, so a start with them is dropped
  assign go = bus_wr && bus_addr == kbo_pkg::OFF_START && bus_wdata[kbo_pkg::START_BIT]
              && idle && mode_reg[1:0] != kbo_pkg::KL_BAD;
  assign wb = !idle && cipher_done;
  // Nk is 4, 6 or 8 words
  assign nk = 4'(4 + 2 * mode_reg[1:0]);

  always_comb begin
    key_next   = key_reg;
    text_next  = text_reg;
    ctrl_next  = ctrl_reg;
    mode_next  = mode_reg;
    st_next    = st_reg;
    start_next = 1'b0;
    kw_next    = kw_reg;
    kl_next    = kl_reg;
    dec_next   = dec_reg;
    state_next = state_reg;
    busy_next  = busy_reg;
    rdata_next = kbo_pkg::WORD_RST;
    ksrc       = 3'h0;
    tsrc       = 2'h0;
    lane       = 2'h0;
    if (bus_wr) begin
      if (key_hit) begin
        key_next[bus_addr[4:2]] = bus_wdata;
      end else if (text_hit && idle) begin
        // text writes during an operation would race the write-back
        text_next[bus_addr[3:2]] = bus_wdata;
      end else if (bus_addr == kbo_pkg::OFF_ORDER) begin
        ctrl_next = bus_wdata[5:0];
      end else if (bus_addr == kbo_pkg::OFF_MODE) begin
        mode_next = bus_wdata[2:0];
      end
    end
    if (go) begin
      st_next    = kbo_pkg::ST_BUSY;
      start_next = 1'b1;
      busy_next  = 1'b1;
      // length and direction from the select code
      kl_next    = mode_reg[1:0];
      dec_next   = mode_reg[kbo_pkg::MODE_DEC_BIT];
      kw_next    = '0;
      for (int i = 0; i < 8; i++) begin
        for (int b = 0; b < 4; b++) begin
          if (i < int'(nk)) begin
            ksrc = ctrl_reg[kbo_pkg::ORD_KEY_WORD] ? 3'(i) : 3'(int'(nk) - 1 - i);
            lane = ctrl_reg[kbo_pkg::ORD_KEY_BYTE] ? 2'(b) : 2'(3 - b);
            // byte b of the word, msb first
            kw_next[255 - 32 * i - 8 * b -: 8] = key_reg[ksrc][8 * lane +: 8];
          end
        end
      end
      // input text map, sampled at start
      for (int c = 0; c < 4; c++) begin
        for (int r = 0; r < 4; r++) begin
          tsrc = ctrl_reg[kbo_pkg::ORD_IN_COL] ? 2'(c) : 2'(3 - c);
          lane = ctrl_reg[kbo_pkg::ORD_IN_BYTE] ? 2'(r) : 2'(3 - r);
          // one text byte per state byte
          state_next[127 - 8 * (r + 4 * c) -: 8] = text_reg[tsrc][8 * lane +: 8];
        end
      end
    end
    if (wb) begin
      st_next = kbo_pkg::ST_IDLE;
      busy_next = 1'b0;
      for (int c = 0; c < 4; c++) begin
        for (int r = 0; r < 4; r++) begin
          tsrc = ctrl_reg[kbo_pkg::ORD_OUT_COL] ? 2'(c) : 2'(3 - c);
          lane = ctrl_reg[kbo_pkg::ORD_OUT_BYTE] ? 2'(r) : 2'(3 - r);
          text_next[tsrc][8 * lane +: 8] = cipher_result[127 - 8 * (r + 4 * c) -: 8];
        end
      end
    end
    if (bus_rd) begin
      if (key_hit) begin
        rdata_next = key_reg[bus_addr[4:2]];
      end else if (text_hit) begin
        rdata_next = text_reg[bus_addr[3:2]];
      end else begin
        case (bus_addr)
          kbo_pkg::OFF_ORDER: begin
            rdata_next = {26'h000_0000, ctrl_reg};
          end
          kbo_pkg::OFF_MODE: begin
            rdata_next = {29'h0000_0000, mode_reg};
          end
          kbo_pkg::OFF_IDLE: begin
            rdata_next = {31'h0000_0000, idle};
          end
          default: begin
            rdata_next = kbo_pkg::WORD_RST;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        key_reg[i] <= kbo_pkg::WORD_RST;
      end
      for (int i = 0; i < 4; i++) begin
        text_reg[i] <= kbo_pkg::WORD_RST;
      end
      ctrl_reg  <= kbo_pkg::ORDER_RST;
      mode_reg  <= kbo_pkg::MODE_RST;
      st_reg    <= kbo_pkg::ST_IDLE;
      rdata_reg <= kbo_pkg::WORD_RST;
      start_reg <= 1'b0;
      kw_reg    <= '0;
      kl_reg    <= 2'h0;
      dec_reg   <= 1'b0;
      state_reg <= '0;
      busy_reg  <= 1'b0;
    end else begin
      key_reg   <= key_next;
      text_reg  <= text_next;
      ctrl_reg  <= ctrl_next;
      mode_reg  <= mode_next;
      st_reg    <= st_next;
      rdata_reg <= rdata_next;
      start_reg <= start_next;
      kw_reg    <= kw_next;
      kl_reg    <= kl_next;
      dec_reg   <= dec_next;
      state_reg <= state_next;
      busy_reg  <= busy_next;
    end
  end

  assign bus_rdata        = rdata_reg;
  assign cipher_start     = start_reg;
  assign cipher_key_words = kw_reg;
  assign cipher_key_len   = kl_reg;
  assign cipher_decrypt   = dec_reg;
  assign cipher_state     = state_reg;
  // own flop, so the pin carries no state decode
  assign busy             = busy_reg;

  a_key_word_rev: assert property (@(posedge core_clk) disable iff (!resetn)
    go && ctrl_reg[1:0] == 2'b00 && mode_reg[1:0] == 2'b00
    |=> kw_reg[255:224] == $past(key_reg[3]) && kw_reg[159:128] == $past(key_reg[0]))
    else $error("key word order wrong");
  a_key_byte_swap: assert property (@(posedge core_clk) disable iff (!resetn)
    go && ctrl_reg[1:0] == 2'b11
    |=> kw_reg[255:248] == $past(key_reg[0][7:0]) && kw_reg[231:224] == $past(key_reg[0][31:24]))
    else $error("key byte order wrong");
  a_key_len_192: assert property (@(posedge core_clk) disable iff (!resetn)
    go && mode_reg[1:0] == 2'b01 && ctrl_reg[1:0] == 2'b00
    |=> kw_reg[255:224] == $past(key_reg[5]) && kw_reg[63:0] == 64'h0000_0000_0000_0000
        && cipher_key_len == 2'h1)
    else $error("192-bit key span wrong");
  a_text_col_rev: assert property (@(posedge core_clk) disable iff (!resetn)
    go && ctrl_reg[3:2] == 2'b00
    |=> state_reg[127:120] == $past(text_reg[3][31:24]) && state_reg[7:0] == $past(text_reg[0][7:0]))
    else $error("text column order wrong");
  a_text_row_swap: assert property (@(posedge core_clk) disable iff (!resetn)
    go && ctrl_reg[3:2] == 2'b11
    |=> state_reg[127:120] == $past(text_reg[0][7:0]) && state_reg[119:112] == $past(text_reg[0][15:8]))
    else $error("text row order wrong");
  a_dir_sampled: assert property (@(posedge core_clk) disable iff (!resetn)
    go |=> cipher_decrypt == $past(mode_reg[2]) && busy ##1 !cipher_start)
    else $error("direction or start pulse wrong");
  a_out_write: assert property (@(posedge core_clk) disable iff (!resetn)
    wb && ctrl_reg[5:4] == 2'b10
    |=> text_reg[0][31:24] == $past(cipher_result[127:120]) && !busy)
    else $error("output write-back order wrong");
  a_out_rev: assert property (@(posedge core_clk) disable iff (!resetn)
    wb && ctrl_reg[5:4] == 2'b01
    |=> text_reg[3][7:0] == $past(cipher_result[127:120]))
    else $error("output byte order wrong");
  a_ctrl_upper: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_wr && bus_addr == kbo_pkg::OFF_ORDER ##1 !bus_wr
    ##1 bus_rd && bus_addr == kbo_pkg::OFF_ORDER
    |=> bus_rdata == {26'h000_0000, $past(bus_wdata[5:0], 3)})
    else $error("order register readback wrong");

  // handshake, latching, key-span and order readback checks
  a_start_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
    cipher_start |=> !cipher_start)
    else $error("start pulse longer than one cycle");
  a_busy_start: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_wr && bus_addr == kbo_pkg::OFF_START && bus_wdata[kbo_pkg::START_BIT] && !busy
    && mode_reg[1:0] != kbo_pkg::KL_BAD |=> cipher_start && busy)
    else $error("valid start not taken");
  a_start_refused: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_wr && bus_addr == kbo_pkg::OFF_START && !busy
    && mode_reg[1:0] == kbo_pkg::KL_BAD |=> !cipher_start && !busy)
    else $error("start with bad mode taken");
  a_busy_end: assert property (@(posedge core_clk) disable iff (!resetn)
    busy && cipher_done |=> !busy)
    else $error("busy not cleared by done");
  a_text_locked: assert property (@(posedge core_clk) disable iff (!resetn)
    busy && !cipher_done
    |=> text_reg[0] == $past(text_reg[0]) && text_reg[1] == $past(text_reg[1])
        && text_reg[2] == $past(text_reg[2]) && text_reg[3] == $past(text_reg[3]))
    else $error("text changed during operation");
  a_stray_done: assert property (@(posedge core_clk) disable iff (!resetn)
    !busy && cipher_done && !bus_wr
    |=> text_reg[0] == $past(text_reg[0]) && text_reg[1] == $past(text_reg[1])
        && text_reg[2] == $past(text_reg[2]) && text_reg[3] == $past(text_reg[3]))
    else $error("idle done changed the text");
  a_key_len_256: assert property (@(posedge core_clk) disable iff (!resetn)
    go && mode_reg[1:0] == 2'b10 && ctrl_reg[1:0] == 2'b10
    |=> kw_reg[31:0] == $past(key_reg[7]) && cipher_key_len == 2'h2)
    else $error("256-bit key span wrong");
  a_key_128_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    go && mode_reg[1:0] == 2'b00 |=> kw_reg[127:0] == 128'h0)
    else $error("unused key words not cleared");
  a_order_upper: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_rd && bus_addr == kbo_pkg::OFF_ORDER |=> bus_rdata[31:6] == 26'h000_0000)
    else $error("order register upper bits not zero");
  a_state_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    busy |=> $stable(cipher_state) && $stable(cipher_key_words) && $stable(cipher_decrypt))
    else $error("latched maps changed during operation");
endmodule
`default_nettype wire

// ### tb_kbo_top.sv
// self-checking bench for the key and text byte-order steering block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic         core_clk      = 1'b0;
  logic         resetn        = 1'b0;
  logic [7:0]   bus_addr      = 8'h00;
  logic [31:0]  bus_wdata     = 32'h0000_0000;
  logic         bus_wr        = 1'b0;
  logic         bus_rd        = 1'b0;
  logic         cipher_done   = 1'b0;
  logic [127:0] cipher_result = 128'h0;
  logic [31:0]  bus_rdata;
  logic         cipher_start;
  logic [255:0] cipher_key_words;
  logic [1:0]   cipher_key_len;
  logic         cipher_decrypt;
  logic [127:0] cipher_state;
  logic         busy;
  logic [31:0]  key_m [8];
  logic [31:0]  txt_m [4];
  logic [2:0]   modes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic [255:0] exp_k;
  logic [127:0] exp_s;
  logic [127:0] res;
  logic [2:0]   mode;
  logic [5:0]   ord;
  int           nk;
  int           bad_count   = 0;
  int           checks_done = 0;

  kbo_steer i_dut (.core_clk(core_clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cipher_start(cipher_start),
    .cipher_key_words(cipher_key_words), .cipher_key_len(cipher_key_len), .cipher_decrypt(cipher_decrypt),
    .cipher_state(cipher_state), .cipher_done(cipher_done), .cipher_result(cipher_result), .busy(busy));

  initial forever #5 core_clk = ~core_clk;

  task automatic cmp(input string nm, input logic [255:0] e, input logic [255:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // a clock edge always passes between strobes, so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 cmp(nm, 256'(e), 256'(bus_rdata));
  endtask

  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rdc("order_rst", kbo_pkg::OFF_ORDER, 32'h0000_0000);
    cmp("out_rst", 256'h0, 256'({cipher_start, busy, cipher_key_len, cipher_decrypt}));
    rdc("idle_rst", kbo_pkg::OFF_IDLE, 32'h0000_0001);
    rdc("unmapped", 8'h40, 32'h0000_0000);
    rdc("start_read", kbo_pkg::OFF_START, 32'h0000_0000);
    for (int k = 0; k < 6; k++) begin
      mode = modes[k];
      ord  = {2'(k + 2), 2'(k + 1), 2'(k)};
      nk   = (mode[1:0] == 2'h0) ? 4 : (mode[1:0] == 2'h1) ? 6 : 8;
      for (int i = 0; i < 8; i++) begin
        key_m[i] = 32'h0302_0100 + {4{8'(4 * i + 40 * k)}};
        wr(kbo_pkg::OFF_KEY_BASE + 8'(4 * i), key_m[i]);
      end
      for (int j = 0; j < 4; j++) begin
        txt_m[j] = 32'h0302_0100 + {4{8'(4 * j + 128 + 20 * k)}};
        wr(kbo_pkg::OFF_TEXT_BASE + 8'(4 * j), txt_m[j]);
      end
      // junk above bit five must vanish
      wr(kbo_pkg::OFF_ORDER, {26'h2aa_aaaa, ord});
      rdc("order", kbo_pkg::OFF_ORDER, {26'h000_0000, ord});
      wr(kbo_pkg::OFF_MODE, {29'h0000_0000, mode});
      exp_k = '0;
      for (int i = 0; i < nk; i++)
        for (int b = 0; b < 4; b++)
          exp_k[255 - 32 * i - 8 * b -: 8] = key_m[ord[1] ? i : nk - 1 - i][8 * (ord[0] ? b : 3 - b) +: 8];
      for (int c = 0; c < 4; c++)
        for (int r = 0; r < 4; r++)
          exp_s[127 - 8 * (r + 4 * c) -: 8] = txt_m[ord[3] ? c : 3 - c][8 * (ord[2] ? r : 3 - r) +: 8];
      for (int n = 0; n < 16; n++)
        res[127 - 8 * n -: 8] = 8'(7 * n + k + 1);
      wr(kbo_pkg::OFF_START, 32'h0000_0001);
      #1 cmp("start", 256'(1'b1), 256'(cipher_start));
      cmp("busy", 256'(1'b1), 256'(busy));
      cmp("key_words", exp_k, cipher_key_words);
      cmp("state", 256'(exp_s), 256'(cipher_state));
      cmp("len_dec", 256'({mode[2], mode[1:0]}), 256'({cipher_decrypt, cipher_key_len}));
      @(posedge core_clk);
      #1 cmp("start_pulse", 256'(1'b0), 256'(cipher_start));
      // refused while busy: text write and a second start
      wr(kbo_pkg::OFF_TEXT_BASE, 32'hdead_beef);
      rdc("text_busy", kbo_pkg::OFF_TEXT_BASE, txt_m[0]);
      wr(kbo_pkg::OFF_START, 32'h0000_0001);
      #1 cmp("start_busy", 256'(1'b0), 256'(cipher_start));
      // output order is taken at write-back; key and text maps stay latched
      ord[5:4] = ~ord[5:4];
      wr(kbo_pkg::OFF_ORDER, {26'h000_0000, ord});
      #1 cmp("key_hold", exp_k, cipher_key_words);
      cmp("state_hold", 256'(exp_s), 256'(cipher_state));
      @(posedge core_clk);
      cipher_done   <= 1'b1;
      cipher_result <= res;
      @(posedge core_clk);
      cipher_done <= 1'b0;
      #1 cmp("busy_done", 256'(1'b0), 256'(busy));
      for (int c = 0; c < 4; c++)
        for (int r = 0; r < 4; r++)
          txt_m[ord[5] ? c : 3 - c][8 * (ord[4] ? r : 3 - r) +: 8] = res[127 - 8 * (r + 4 * c) -: 8];
      for (int j = 0; j < 4; j++)
        rdc("text_out", kbo_pkg::OFF_TEXT_BASE + 8'(4 * j), txt_m[j]);
      rdc("idle", kbo_pkg::OFF_IDLE, 32'h0000_0001);
    end
    // stray done while idle leaves the text alone
    @(posedge core_clk);
    cipher_done   <= 1'b1;
    cipher_result <= ~res;
    @(posedge core_clk);
    cipher_done <= 1'b0;
    rdc("text_stray", kbo_pkg::OFF_TEXT_BASE, txt_m[0]);
    // both select codes without a key length
    for (int m = 3; m < 8; m += 4) begin
      wr(kbo_pkg::OFF_MODE, 32'(m));
      wr(kbo_pkg::OFF_START, 32'h0000_0001);
      #1 cmp("start_bad_mode", 256'(1'b0), 256'({busy, cipher_start}));
    end
    conclude();
  end
endmodule
`default_nettype wire
